//--- verilog/incl_pkg.sv
// constants, enumerations and carrier structs of the accelerometer
// conditioning and angle status block; no logic lives here
package incl_pkg;

	// ************************************************************
	// object dictionary indices and subindices
	// ************************************************************
	localparam logic [15:0] IDX_FILT_EN     = 16'h2004;
	localparam logic [15:0] IDX_FILT_CUT    = 16'h2005;
	localparam logic [15:0] IDX_AXIS_RES    = 16'h2010;
	localparam logic [15:0] IDX_AXIS_INV    = 16'h2011;
	localparam logic [15:0] IDX_AXIS_OFS    = 16'h2020;
	localparam logic [15:0] IDX_ANGLE_TYPE  = 16'h2100;
	localparam logic [15:0] IDX_TILT_RANGE  = 16'h2101;
	localparam logic [15:0] IDX_MAX_GERR    = 16'h2102;
	localparam logic [15:0] IDX_FUSION_EN   = 16'h2103;
	localparam logic [15:0] IDX_PITCH       = 16'h4030;
	localparam logic [15:0] IDX_ROLL        = 16'h4040;
	localparam logic [15:0] IDX_GANGLE      = 16'h4050;
	localparam logic [15:0] IDX_GERR        = 16'h4060;
	localparam logic [15:0] IDX_FSTATE      = 16'h4080;
	localparam logic [15:0] IDX_FSTATE_INV  = 16'h4090;
	localparam logic [15:0] IDX_LATENCY     = 16'h4130;
	localparam logic [15:0] IDX_TRUST       = 16'h4140;
	localparam logic [15:0] IDX_RAW_LAT     = 16'h4200;
	localparam logic [15:0] IDX_RAW_TRUST   = 16'h4210;
	localparam logic [15:0] IDX_RAW_PITCH   = 16'h4220;
	localparam logic [15:0] IDX_RAW_ROLL    = 16'h4230;
	localparam logic [15:0] IDX_RAW_GANGLE  = 16'h4240;
	localparam logic [15:0] IDX_RAW_GERR    = 16'h4250;
	localparam logic [7:0]  SUB_COUNT       = 8'h00;  // array entry count
	localparam logic [7:0]  AXIS_COUNT      = 8'h03;  // x, y, z

	// ************************************************************
	// reset values and legal ranges
	// ************************************************************
	localparam logic [7:0]  FILT_EN_RST     = 8'h01;
	localparam logic [7:0]  FILT_CUT_RST    = 8'h05;
	localparam logic [7:0]  FILT_CUT_MIN    = 8'h01;
	localparam logic [7:0]  FILT_CUT_MAX    = 8'h23;  // 35 Hz
	localparam logic [15:0] RES_RST         = 16'h03E8;
	localparam logic [15:0] RES_MIN         = 16'h0001;
	localparam logic [15:0] RES_MAX         = 16'h03E8;
	localparam logic [15:0] SCALE_NUM       = 16'h03E8;  // the 1000
	localparam logic [7:0]  TILT_RANGE_RST  = 8'h01;     // 1 = 180 deg
	localparam logic [31:0] MAX_GERR_RST    = 32'h3E4CCCCD;  // 0.2 float
	localparam logic [31:0] MAX_GERR_LIMIT  = 32'h3F800000;  // 1.0 float
	localparam logic [31:0] GERR_CLAMP      = 32'h3F000000;  // 0.5 float
	localparam logic [7:0]  FUSION_EN_RST   = 8'h01;
	localparam logic [7:0]  BOOL_MAX        = 8'h01;
	localparam int          FLOAT_SIGN      = 31;

	// sensor temperature window, degrees C
	localparam logic signed [15:0] TEMP_MIN = -16'sd40;
	localparam logic signed [15:0] TEMP_MAX = 16'sd125;

	// angle limits in whole degrees
	localparam int DEG_90  = 90;
	localparam int DEG_180 = 180;

	// ************************************************************
	// enumerations
	// ************************************************************
	typedef enum logic [7:0] {
		ANGLE_EULER = 8'h00,
		ANGLE_TILT  = 8'h01,
		ANGLE_UNIT  = 8'h02
	} angle_type_e;

	typedef enum logic [7:0] {
		TRUST_OK      = 8'h00,
		TRUST_SUSPECT = 8'h01,
		TRUST_ERROR   = 8'h02
	} trust_e;

	typedef enum logic [7:0] {
		FUSE_OFF     = 8'h00,
		FUSE_ON      = 8'h01,
		FUSE_SUSPEND = 8'h02
	} fusion_state_e;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic               req;    // one-cycle access request
		logic               write;  // 1 write, 0 read
		logic [15:0]        index;  // object index
		logic [7:0]         sub;    // subindex
		logic [31:0]        wdata;  // write value, low bits used
	} od_req_s;

	typedef struct packed {
		logic               ack;    // access done pulse
		logic               abort;  // access refused pulse
		logic [31:0]        rdata;  // read value
	} od_rsp_s;

	typedef struct packed {
		logic signed [15:0] pitch;    // angle counts
		logic signed [15:0] roll;     // angle counts
		logic signed [15:0] gravity;  // angle counts
		logic [31:0]        gerr;     // float, g
		logic [15:0]        latency;  // ms
	} angle_set_s;

	typedef struct packed {
		logic signed [15:0] accel;    // accelerometer temperature
		logic signed [15:0] gyro_x;   // gyroscope temperatures
		logic signed [15:0] gyro_y;
		logic signed [15:0] gyro_z;
	} temps_s;

endpackage

//--- verilog/accel_angle_status.sv
// accelerometer output conditioning plus angle output status/encoding
// assumes: single clock, all inputs but the async sys_rst already synchronous to it; the
// fusion engine outside supplies fused and plain angle sets
module accel_angle_status #(
	parameter int ACC_W          = 16,   // accelerometer sample width
	parameter int FRAC_W         = 8,    // filter fraction bits
	parameter int CNT_PER_DEG    = 100   // angle counts per degree
) (
	input  wire logic                   clock,          // 100 MHz
	input  wire logic                   sys_rst,        // async, high
	input  wire logic                   ce,             // freeze when low
	input  wire incl_pkg::od_req_s      od_req,         // dictionary access
	output incl_pkg::od_rsp_s           od_rsp,         // access answer
	input  wire logic                   acc_valid,      // new sample
	input  wire logic [2:0][ACC_W-1:0]  acc_in,         // x, y, z samples
	output logic                        acc_out_valid,  // result pulse
	output logic [2:0][31:0]            acc_out,        // scaled axes
	input  wire incl_pkg::angle_set_s   fused_in,       // fusion result
	input  wire incl_pkg::angle_set_s   plain_in,       // no-fusion result
	input  wire incl_pkg::temps_s       temps,          // sensor temps
	input  wire logic                   acc_sat,        // accel saturated
	input  wire logic                   gyro_sat,       // gyro saturated
	input  wire logic                   sensor_fault,   // any malfunction
	output incl_pkg::angle_set_s        angle_out,      // regular set
	output incl_pkg::angle_set_s        raw_angle_out,  // uncompensated
	output logic [7:0]                  angle_trust_level,     // 0/1/2
	output logic [7:0]                  raw_angle_trust_level, // 0/1/2
	output logic [7:0]                  fusion_state,          // 0/1/2
	output logic [7:0]                  fusion_state_inverted, // 1/0/2
	output logic [7:0]                  angle_type,     // current type
	output logic                        fusion_active   // fusion used
);

	localparam int FW = ACC_W + FRAC_W;  // filter state width

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [7:0]             filt_en;     // filter on/off
		logic [7:0]             filt_cut;    // cut-off, Hz
		logic [2:0][15:0]       res;         // per axis resolution
		logic [2:0]             inv;         // per axis inversion
		logic [2:0][31:0]       ofs;         // per axis offset
		logic [7:0]             atype;       // angle type
		logic [7:0]             tilt;        // 0 = 90, 1 = 180
		logic [31:0]            max_gerr;    // float limit
		logic [7:0]             fuse_en;     // fusion enable
		logic [2:0][FW-1:0]     filt;        // filter memories
		logic                   out_valid;   // result pulse
		logic [2:0][31:0]       out;         // scaled axes
		incl_pkg::angle_set_s   ang;         // regular set
		incl_pkg::angle_set_s   raw;         // uncompensated set
		logic [7:0]             trust;       // regular trust
		logic [7:0]             raw_trust;   // uncompensated trust
		logic [7:0]             fstate;      // fusion state
		logic [7:0]             fstate_inv;  // inverted fusion state
		logic                   factive;     // fusion in use
		incl_pkg::od_rsp_s      rsp;         // access answer
	} state_s;

	state_s cur;       // registered state
	state_s next_cur;  // next state

	// ************************************************************
	// helpers
	// ************************************************************

	// limit a signed angle to +/- lim degrees
	function automatic logic signed [15:0] clamp_sym(
		input logic signed [15:0] v, input int lim);
		logic signed [31:0] hi;
		hi = 32'(lim * CNT_PER_DEG);
		if (32'(v) > hi)
			clamp_sym = 16'(hi);
		else if (32'(v) < -hi)
			clamp_sym = 16'(-hi);
		else
			clamp_sym = v;
	endfunction

	// limit a positive float to [0, 0.5]; negatives, negative nan included, to 0
	function automatic logic [31:0] clamp_gerr(input logic [31:0] f);
		if (f[incl_pkg::FLOAT_SIGN])
			clamp_gerr = '0;
		else if (f > incl_pkg::GERR_CLAMP)
			clamp_gerr = incl_pkg::GERR_CLAMP;
		else
			clamp_gerr = f;
	endfunction

	// pitch/roll limit in degrees for the current type
	function automatic int pr_limit(input logic [7:0] t,
		input logic [7:0] tilt, input logic is_pitch);
		case (t)
			incl_pkg::ANGLE_EULER: pr_limit = is_pitch ?
				incl_pkg::DEG_90 : incl_pkg::DEG_180;
			incl_pkg::ANGLE_TILT: pr_limit = (tilt != '0) ?
				incl_pkg::DEG_180 : incl_pkg::DEG_90;
			default: pr_limit = incl_pkg::DEG_180;
		endcase
	endfunction

	// shape one angle set to the legal ranges
	function automatic incl_pkg::angle_set_s shape(
		input incl_pkg::angle_set_s a, input logic [7:0] t,
		input logic [7:0] tilt);
		logic signed [15:0] g;
		shape = a;
		shape.pitch = clamp_sym(a.pitch, pr_limit(t, tilt, 1'b1));
		shape.roll = clamp_sym(a.roll, pr_limit(t, tilt, 1'b0));
		g = clamp_sym(a.gravity, incl_pkg::DEG_180);
		shape.gravity = (g < 0) ? '0 : g;
		shape.gerr = clamp_gerr(a.gerr);
	endfunction

	// temperature outside the trusted window
	function automatic logic temp_bad(input logic signed [15:0] t);
		temp_bad = (t < incl_pkg::TEMP_MIN) || (t > incl_pkg::TEMP_MAX);
	endfunction

	// filter shift from cut-off: lower cut-off, heavier smoothing
	function automatic int cut_shift(input logic [7:0] c);
		if (c >= 8'h10)
			cut_shift = 1;
		else if (c >= 8'h08)
			cut_shift = 2;
		else if (c >= 8'h04)
			cut_shift = 3;
		else
			cut_shift = 4;
	endfunction

	// ************************************************************
	// next-state logic
	// ************************************************************
	always_comb begin
		logic               wr;        // write request
		logic               ok;        // write accepted
		logic               ax_sub;    // subindex names an axis
		logic [1:0]         ax;        // axis number
		logic               gyro_hot;  // any gyro temp out of window
		logic               acc_hot;   // accel temp out of window
		logic               err_any;   // saturation or fault
		logic               suspend;   // fusion suspended
		logic signed [FW-1:0] x;       // aligned sample
		logic signed [FW-1:0] f;       // filtered sample
		logic signed [33:0] s;         // signed, offset sum
		logic signed [47:0] p;         // scaled product
		logic signed [47:0] q;         // quotient
		wr = 1'b0;
		ok = 1'b0;
		ax_sub = 1'b0;
		ax = '0;
		gyro_hot = 1'b0;
		acc_hot = 1'b0;
		err_any = 1'b0;
		suspend = 1'b0;
		x = '0;
		f = '0;
		s = '0;
		p = '0;
		q = '0;
		next_cur = cur;
		next_cur.out_valid = 1'b0;
		next_cur.rsp.ack = 1'b0;
		next_cur.rsp.abort = 1'b0;

		// axis conditioning on each new sample
		if (acc_valid) begin
			for (int i = 0; i < 3; i++) begin
				x = FW'(signed'(acc_in[i])) <<< FRAC_W;
				if (cur.filt_en == incl_pkg::FILT_EN_RST) begin
					// cut-off only steers the filter while it is on
					f = signed'(cur.filt[i]) + ((x - signed'(cur.filt[i]))
						>>> cut_shift(cur.filt_cut));
				end else begin
					f = x;
				end
				next_cur.filt[i] = f;
				s = 34'(f >>> FRAC_W);
				if (cur.inv[i])
					s = -s;
				s = s + 34'(signed'(cur.ofs[i]));
				p = 48'(s) * 48'(signed'({1'b0, incl_pkg::SCALE_NUM}));
				q = p / 48'(signed'({1'b0, cur.res[i]}));
				next_cur.out[i] = q[31:0];
			end
			next_cur.out_valid = 1'b1;
		end

		// fusion state; suspension needs fusion to be enabled
		err_any = acc_sat || gyro_sat || sensor_fault;
		suspend = (cur.fuse_en != '0) &&
			(gyro_sat || sensor_fault);
		if (cur.fuse_en == '0) begin
			next_cur.fstate = incl_pkg::FUSE_OFF;
			next_cur.fstate_inv = incl_pkg::FUSE_ON;
		end else if (suspend) begin
			next_cur.fstate = incl_pkg::FUSE_SUSPEND;
			next_cur.fstate_inv = incl_pkg::FUSE_SUSPEND;
		end else begin
			next_cur.fstate = incl_pkg::FUSE_ON;
			next_cur.fstate_inv = incl_pkg::FUSE_OFF;
		end
		next_cur.factive = (cur.fuse_en != '0) && !suspend;

		// angle sets; plain path never sees fusion
		next_cur.raw = shape(plain_in, cur.atype, cur.tilt);
		if (next_cur.factive)
			next_cur.ang = shape(fused_in, cur.atype, cur.tilt);
		else
			next_cur.ang = next_cur.raw;

		// trust levels: error beats suspect
		acc_hot = temp_bad(temps.accel);
		gyro_hot = temp_bad(temps.gyro_x) || temp_bad(temps.gyro_y) ||
			temp_bad(temps.gyro_z);
		if (err_any || (!next_cur.factive &&
			(plain_in.gerr > cur.max_gerr)))
			next_cur.trust = incl_pkg::TRUST_ERROR;
		else if (acc_hot || (next_cur.factive && gyro_hot))
			next_cur.trust = incl_pkg::TRUST_SUSPECT;
		else
			next_cur.trust = incl_pkg::TRUST_OK;
		// plain path is never fused, so the gravity limit always counts
		if (err_any || (plain_in.gerr > cur.max_gerr))
			next_cur.raw_trust = incl_pkg::TRUST_ERROR;
		else if (acc_hot)
			next_cur.raw_trust = incl_pkg::TRUST_SUSPECT;
		else
			next_cur.raw_trust = incl_pkg::TRUST_OK;

		// ********************************************************
		// dictionary access
		// ********************************************************
		ax_sub = (od_req.sub != incl_pkg::SUB_COUNT) &&
			(od_req.sub <= incl_pkg::AXIS_COUNT);
		ax = 2'(od_req.sub - 8'h01);
		wr = od_req.req && od_req.write;
		if (od_req.req) begin
			next_cur.rsp.rdata = '0;
			case (od_req.index)
				incl_pkg::IDX_FILT_EN: begin
					next_cur.rsp.rdata = 32'(cur.filt_en);
					ok = od_req.wdata <= 32'(incl_pkg::BOOL_MAX);
					if (wr && ok)
						next_cur.filt_en = od_req.wdata[7:0];
				end
				incl_pkg::IDX_FILT_CUT: begin
					next_cur.rsp.rdata = 32'(cur.filt_cut);
					ok = (od_req.wdata >= 32'(incl_pkg::FILT_CUT_MIN)) &&
						(od_req.wdata <= 32'(incl_pkg::FILT_CUT_MAX));
					if (wr && ok)
						next_cur.filt_cut = od_req.wdata[7:0];
				end
				incl_pkg::IDX_AXIS_RES: begin
					if (!ax_sub) begin
						next_cur.rsp.rdata = 32'(incl_pkg::AXIS_COUNT);
					end else begin
						next_cur.rsp.rdata = 32'(cur.res[ax]);
						ok = (od_req.wdata >= 32'(incl_pkg::RES_MIN)) &&
							(od_req.wdata <= 32'(incl_pkg::RES_MAX));
						if (wr && ok)
							next_cur.res[ax] = od_req.wdata[15:0];
					end
				end
				incl_pkg::IDX_AXIS_INV: begin
					if (!ax_sub) begin
						next_cur.rsp.rdata = 32'(incl_pkg::AXIS_COUNT);
					end else begin
						next_cur.rsp.rdata = 32'(cur.inv[ax]);
						ok = od_req.wdata <= 32'(incl_pkg::BOOL_MAX);
						if (wr && ok)
							next_cur.inv[ax] = od_req.wdata[0];
					end
				end
				incl_pkg::IDX_AXIS_OFS: begin
					if (!ax_sub) begin
						next_cur.rsp.rdata = 32'(incl_pkg::AXIS_COUNT);
					end else begin
						next_cur.rsp.rdata = cur.ofs[ax];
						ok = 1'b1;
						if (wr)
							next_cur.ofs[ax] = od_req.wdata;
					end
				end
				incl_pkg::IDX_ANGLE_TYPE: begin
					next_cur.rsp.rdata = 32'(cur.atype);
					ok = od_req.wdata <= 32'(incl_pkg::ANGLE_UNIT);
					if (wr && ok)
						next_cur.atype = od_req.wdata[7:0];
				end
				incl_pkg::IDX_TILT_RANGE: begin
					next_cur.rsp.rdata = 32'(cur.tilt);
					ok = od_req.wdata <= 32'(incl_pkg::BOOL_MAX);
					if (wr && ok)
						next_cur.tilt = od_req.wdata[7:0];
				end
				incl_pkg::IDX_MAX_GERR: begin
					next_cur.rsp.rdata = cur.max_gerr;
					ok = od_req.wdata <= incl_pkg::MAX_GERR_LIMIT;
					if (wr && ok)
						next_cur.max_gerr = od_req.wdata;
				end
				incl_pkg::IDX_FUSION_EN: begin
					next_cur.rsp.rdata = 32'(cur.fuse_en);
					ok = od_req.wdata <= 32'(incl_pkg::BOOL_MAX);
					if (wr && ok)
						next_cur.fuse_en = od_req.wdata[7:0];
				end
				incl_pkg::IDX_PITCH:
					next_cur.rsp.rdata = 32'(signed'(cur.ang.pitch));
				incl_pkg::IDX_ROLL:
					next_cur.rsp.rdata = 32'(signed'(cur.ang.roll));
				incl_pkg::IDX_GANGLE:
					next_cur.rsp.rdata = 32'(signed'(cur.ang.gravity));
				incl_pkg::IDX_GERR:
					next_cur.rsp.rdata = cur.ang.gerr;
				incl_pkg::IDX_FSTATE:
					next_cur.rsp.rdata = 32'(cur.fstate);
				incl_pkg::IDX_FSTATE_INV:
					next_cur.rsp.rdata = 32'(cur.fstate_inv);
				incl_pkg::IDX_LATENCY:
					next_cur.rsp.rdata = 32'(cur.ang.latency);
				incl_pkg::IDX_TRUST:
					next_cur.rsp.rdata = 32'(cur.trust);
				incl_pkg::IDX_RAW_LAT:
					next_cur.rsp.rdata = 32'(cur.raw.latency);
				incl_pkg::IDX_RAW_TRUST:
					next_cur.rsp.rdata = 32'(cur.raw_trust);
				incl_pkg::IDX_RAW_PITCH:
					next_cur.rsp.rdata = 32'(cur.raw.pitch);
				incl_pkg::IDX_RAW_ROLL:
					next_cur.rsp.rdata = 32'(cur.raw.roll);
				incl_pkg::IDX_RAW_GANGLE:
					next_cur.rsp.rdata = 32'(cur.raw.gravity);
				incl_pkg::IDX_RAW_GERR:
					next_cur.rsp.rdata = cur.raw.gerr;
				default: ;  // unknown index: writes aborted below, reads acked with zero data
			endcase
			// read-only objects, counts and bad values refuse writes
			if (wr && !ok)
				next_cur.rsp.abort = 1'b1;
			else
				next_cur.rsp.ack = 1'b1;
			if (!od_req.write && !(ax_sub || (od_req.index !=
				incl_pkg::IDX_AXIS_RES && od_req.index !=
				incl_pkg::IDX_AXIS_INV && od_req.index !=
				incl_pkg::IDX_AXIS_OFS)) && od_req.sub > incl_pkg::AXIS_COUNT) begin
				next_cur.rsp.ack = 1'b0;
				next_cur.rsp.abort = 1'b1;
			end
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cur <= '0;
			cur.filt_en <= incl_pkg::FILT_EN_RST;
			cur.filt_cut <= incl_pkg::FILT_CUT_RST;
			cur.res <= {3{incl_pkg::RES_RST}};
			cur.tilt <= incl_pkg::TILT_RANGE_RST;
			cur.max_gerr <= incl_pkg::MAX_GERR_RST;
			cur.fuse_en <= incl_pkg::FUSION_EN_RST;
		end else if (ce) begin
			cur <= next_cur;
		end
	end

	// ************************************************************
	// outputs, all straight from the state register
	// ************************************************************
	assign od_rsp                = cur.rsp;
	assign acc_out_valid         = cur.out_valid;
	assign acc_out               = cur.out;
	assign angle_out             = cur.ang;
	assign raw_angle_out         = cur.raw;
	assign angle_trust_level     = cur.trust;
	assign raw_angle_trust_level = cur.raw_trust;
	assign fusion_state          = cur.fstate;
	assign fusion_state_inverted = cur.fstate_inv;
	assign angle_type            = cur.atype;
	assign fusion_active         = cur.factive;

endmodule

//--- testbench/accel_angle_status_monitor.sv
// assertions on the conditioning and angle status ports
// assumes: bound into accel_angle_status, ce held high
module accel_angle_status_chk #(
	parameter int CNT_PER_DEG = 100  // angle counts per degree
) (
	input wire logic                 clock,                 // clock
	input wire logic                 sys_rst,               // reset
	input wire incl_pkg::od_req_s    od_req,                // access
	input wire incl_pkg::od_rsp_s    od_rsp,                // answer
	input wire logic                 acc_sat,               // saturated
	input wire logic                 gyro_sat,              // gyro sat
	input wire logic                 sensor_fault,          // malfunction
	input wire incl_pkg::temps_s     temps,                 // temps
	input wire incl_pkg::angle_set_s angle_out,             // regular
	input wire incl_pkg::angle_set_s raw_angle_out,         // raw
	input wire logic [7:0]           angle_trust_level,     // trust
	input wire logic [7:0]           raw_angle_trust_level, // raw trust
	input wire logic [7:0]           fusion_state,          // state
	input wire logic [7:0]           fusion_state_inverted, // inverse
	input wire logic [7:0]           angle_type             // type
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	localparam int LIM90 = 90 * CNT_PER_DEG;    // euler pitch bound
	localparam int LIM180 = 180 * CNT_PER_DEG;  // gravity bound
	bad_write_a: assert property (
		od_req.req && od_req.write && od_req.index == incl_pkg::IDX_FILT_EN
		&& od_req.wdata > 32'h1 |=> od_rsp.abort && !od_rsp.ack)
		else $error("bad write not refused");
	fuse_off_eq_a: assert property (
		fusion_state == 8'h00 |-> angle_out == raw_angle_out)
		else $error("fusion off but sets differ");
	inv_state_a: assert property (
		fusion_state == 8'h01 |-> fusion_state_inverted == 8'h00)
		else $error("inverted state wrong");
	suspend_cause_a: assert property (
		fusion_state == 8'h02 |-> $past(gyro_sat || sensor_fault)
		&& fusion_state_inverted == 8'h02) else $error("suspend cause");
	sat_trust_a: assert property (
		acc_sat |=> angle_trust_level == 8'h02
		&& raw_angle_trust_level == 8'h02) else $error("sat trust");
	temp_trust_a: assert property (
		temps.accel > incl_pkg::TEMP_MAX |=> angle_trust_level != 8'h00)
		else $error("hot sensor trusted");
	gravity_range_a: assert property (
		angle_out.gravity >= 0 && angle_out.gravity <= LIM180 &&
		raw_angle_out.gravity >= 0 && raw_angle_out.gravity <= LIM180)
		else $error("gravity angle out of range");
	gerr_clamp_a: assert property (
		angle_out.gerr <= incl_pkg::GERR_CLAMP
		&& raw_angle_out.gerr <= incl_pkg::GERR_CLAMP) else $error("gerr");
	euler_pitch_a: assert property (
		angle_type == 8'h00 && $past(angle_type) == 8'h00 |->
		raw_angle_out.pitch <= LIM90 && raw_angle_out.pitch >= -LIM90)
		else $error("euler pitch out of range");
	cover property (fusion_state == 8'h02);
	cover property (od_rsp.abort);
	cover property (angle_trust_level == 8'h01);
endmodule
bind accel_angle_status accel_angle_status_chk #(
	.CNT_PER_DEG(CNT_PER_DEG)) i_accel_angle_status_chk (
	.clock(clock), .sys_rst(sys_rst), .od_req(od_req), .od_rsp(od_rsp),
	.acc_sat(acc_sat), .gyro_sat(gyro_sat), .sensor_fault(sensor_fault),
	.temps(temps), .angle_out(angle_out), .raw_angle_out(raw_angle_out),
	.angle_trust_level(angle_trust_level), .angle_type(angle_type),
	.raw_angle_trust_level(raw_angle_trust_level),
	.fusion_state(fusion_state),
	.fusion_state_inverted(fusion_state_inverted));

//--- testbench/od_host.sv
// network host model issuing dictionary reads and writes
// assumes: answer within three cycles of the taking edge
module od_host (
	input  wire logic              clock,  // block clock
	output incl_pkg::od_req_s      od_req, // request to block
	input  wire incl_pkg::od_rsp_s od_rsp  // answer from block
);
	timeunit 1ns;
	timeprecision 1ps;
	initial od_req = '0;  // idle at time zero
	// one-cycle request; released fields show inverse, not stale data
	task automatic xfer(input logic w, input logic [15:0] i,
		input logic [7:0] s, input logic [31:0] d,
		output logic [31:0] q, output logic ab);
		int n;
		@(negedge clock);
		od_req = '{1'b1, w, i, s, d};
		@(negedge clock);
		od_req = '{1'b0, ~w, ~i, ~s, ~d};
		for (n = 0; n < 3 && !(od_rsp.ack || od_rsp.abort); n++)
			@(negedge clock);
		q = od_rsp.rdata;
		ab = od_rsp.abort || !od_rsp.ack;  // silence counts as refusal
	endtask
endmodule

//--- testbench/accel_angle_status_tb.sv
// self-checking bench for the conditioning and angle status block
// assumes: od_host drives the dictionary port, ce held high
module accel_angle_status_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clock, sys_rst, acc_valid, acc_out_valid;
	logic                 acc_sat, gyro_sat, sensor_fault, fusion_active;
	logic [7:0]           angle_type;   // current type
	logic [2:0][15:0]     acc_in;       // x at index 0
	logic [2:0][31:0]     acc_out;      // scaled axes
	incl_pkg::od_req_s    od_req;       // host request
	incl_pkg::od_rsp_s    od_rsp;       // block answer
	incl_pkg::angle_set_s fused_in, plain_in, angle_out, raw_angle_out;
	incl_pkg::temps_s     temps;        // temperatures
	logic [31:0]          q;            // read data
	logic                 ab;           // refused flag
	int                   num_errors = 0, n_tests = 0;
	accel_angle_status i_accel_angle_status (.clock(clock),
		.sys_rst(sys_rst), .ce(1'b1), .od_req(od_req), .od_rsp(od_rsp),
		.acc_valid(acc_valid), .acc_in(acc_in), .acc_out(acc_out),
		.acc_out_valid(acc_out_valid), .fused_in(fused_in),
		.plain_in(plain_in), .temps(temps), .acc_sat(acc_sat),
		.gyro_sat(gyro_sat), .sensor_fault(sensor_fault),
		.angle_out(angle_out), .raw_angle_out(raw_angle_out),
		.angle_trust_level(), .raw_angle_trust_level(),
		.fusion_state(), .fusion_state_inverted(),
		.angle_type(angle_type), .fusion_active(fusion_active));
	od_host i_od_host (.clock(clock), .od_req(od_req), .od_rsp(od_rsp));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// compare and count
	task automatic chk(input string n, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] e);
		i_od_host.xfer(1'b0, i, s, 32'h0, q, ab);
		chk($sformatf("read %h.%0d", i, s), e, q);
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d, input logic e);
		i_od_host.xfer(1'b1, i, s, d, q, ab);
		chk($sformatf("refusal %h.%0d", i, s), {31'h0, e}, {31'h0, ab});
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, far beyond the some seventy cycles of the run
	initial begin
		#100000;
		num_errors++;
		close_out();
	end
	initial begin
		{sys_rst, acc_valid, acc_sat, gyro_sat, sensor_fault} = 5'h10;
		{acc_in, fused_in, plain_in, temps} = '0;
		repeat (3) @(negedge clock);
		sys_rst = 1'b0;
		rd(incl_pkg::IDX_FILT_EN, 8'h00, 32'h1);
		rd(incl_pkg::IDX_FILT_CUT, 8'h00, 32'h5);
		rd(incl_pkg::IDX_AXIS_RES, 8'h01, 32'h3E8);
		rd(incl_pkg::IDX_AXIS_INV, 8'h03, 32'h0);
		rd(incl_pkg::IDX_FSTATE, 8'h00, 32'h1);
		rd(incl_pkg::IDX_FSTATE_INV, 8'h00, 32'h0);
		wr(incl_pkg::IDX_AXIS_RES, 8'h01, 32'h1F4, 1'b0);
		wr(incl_pkg::IDX_AXIS_RES, 8'h01, 32'h3E9, 1'b1);
		wr(incl_pkg::IDX_FILT_EN, 8'h00, 32'h2, 1'b1);
		rd(incl_pkg::IDX_AXIS_RES, 8'h01, 32'h1F4);
		wr(incl_pkg::IDX_FILT_EN, 8'h00, 32'h0, 1'b0);
		wr(incl_pkg::IDX_AXIS_INV, 8'h02, 32'h1, 1'b0);
		wr(incl_pkg::IDX_AXIS_OFS, 8'h03, 32'hA, 1'b0);
		acc_in = {3{16'h0064}};
		acc_valid = 1'b1;
		@(negedge clock);
		acc_valid = 1'b0;
		chk("sample valid", 32'h1, {31'h0, acc_out_valid});
		chk("x scaled", 32'hC8, acc_out[0]);
		chk("y inverted", 32'hFFFFFF9C, acc_out[1]);
		chk("z offset", 32'h6E, acc_out[2]);
		wr(incl_pkg::IDX_FILT_EN, 8'h00, 32'h1, 1'b0);
		acc_in = {3{16'h0164}};
		acc_valid = 1'b1;
		@(negedge clock);
		acc_valid = 1'b0;
		chk("x filtered", 32'h108, acc_out[0]);
		fused_in.pitch = -16'sd256;
		plain_in.pitch = 16'sd512;
		plain_in.latency = 16'h0007;
		rd(incl_pkg::IDX_PITCH, 8'h00, 32'hFFFFFF00);
		rd(incl_pkg::IDX_RAW_PITCH, 8'h00, 32'h200);
		rd(incl_pkg::IDX_RAW_LAT, 8'h00, 32'h7);
		wr(incl_pkg::IDX_FUSION_EN, 8'h00, 32'h0, 1'b0);
		rd(incl_pkg::IDX_FSTATE, 8'h00, 32'h0);
		rd(incl_pkg::IDX_FSTATE_INV, 8'h00, 32'h1);
		chk("fusion active", 32'h0, {31'h0, fusion_active});
		rd(incl_pkg::IDX_PITCH, 8'h00, 32'h200);
		gyro_sat = 1'b1;
		rd(incl_pkg::IDX_FSTATE, 8'h00, 32'h0);
		wr(incl_pkg::IDX_FUSION_EN, 8'h00, 32'h1, 1'b0);
		rd(incl_pkg::IDX_FSTATE, 8'h00, 32'h2);
		rd(incl_pkg::IDX_FSTATE_INV, 8'h00, 32'h2);
		{gyro_sat, acc_sat} = 2'b01;
		rd(incl_pkg::IDX_TRUST, 8'h00, 32'h2);
		acc_sat = 1'b0;
		temps.accel = 16'sd126;
		rd(incl_pkg::IDX_TRUST, 8'h00, 32'h1);
		temps.accel = 16'sd0;
		plain_in = '{16'sd10000, 16'sd0, 16'sd20000, 32'h3F800000, 16'h7};
		rd(incl_pkg::IDX_RAW_GANGLE, 8'h00, 32'h4650);
		rd(incl_pkg::IDX_RAW_GERR, 8'h00, 32'h3F000000);
		rd(incl_pkg::IDX_RAW_PITCH, 8'h00, 32'h2328);
		wr(incl_pkg::IDX_ANGLE_TYPE, 8'h00, 32'h2, 1'b0);
		chk("angle type", 32'h2, {24'h0, angle_type});
		rd(incl_pkg::IDX_RAW_PITCH, 8'h00, 32'h2710);
		close_out();
	end
endmodule
